//--- hw/tsc_pkg.sv
package tsc_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int LVL_W = 4;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ARM_ADDR = 6'h00;
  localparam logic [ADDR_W-1:0] SEQ_ADDR = 6'h04;
  localparam logic [ADDR_W-1:0] REPLY_ADDR = 6'h08;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 6'h0C;
  localparam logic [ADDR_W-1:0] SEL_ADDR = 6'h10;
  localparam logic [ADDR_W-1:0] STORE_ADDR = 6'h14;

  // SEQ register fields
  localparam int SEQ_NUM_LSB = 0;
  localparam int SEQ_TRIG_LSB = 8;

  // Level limits
  localparam logic [LVL_W-1:0] MIN_LEVELS = 4'h2;
  localparam logic [LVL_W-1:0] MAX_LEVELS_RUN = 4'h8;
  localparam logic [LVL_W-1:0] MAX_LEVELS_EXT = 4'h7;
  localparam logic [LVL_W-1:0] MIN_TRIG = 4'h1;
  localparam logic [LVL_W-1:0] RESET_LEVELS = 4'h2;
  localparam logic [LVL_W-1:0] RESET_TRIG = 4'h1;

  // Reply characters
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_COMMA = 8'h2C;
  localparam logic [7:0] ASCII_NL = 8'h0A;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TSC_ANY_STATE,
    TSC_NO_STATE,
    TSC_EXPR,
    TSC_BAD_KIND
  } tsc_kind_t;

  // Group 1: A,B,C,D, inside_bounds_term, outside_bounds_term; group 2: E..H
  typedef struct packed {
    logic combine_and;
    logic g2_and;
    logic [3:0] g2_mask;
    logic g1_and;
    logic [5:0] g1_mask;
    tsc_kind_t kind;
  } tsc_qual_t;

  localparam int QUAL_W = $bits(tsc_qual_t);
  localparam tsc_qual_t QUAL_DEFAULT = '{combine_and: 1'b0, g2_and: 1'b0, g2_mask: 4'h0,
                                        g1_and: 1'b0, g1_mask: 6'h00, kind: TSC_ANY_STATE};

  // Pattern term hits from the comparators
  typedef struct packed {
    logic outside_bounds_term;
    logic inside_bounds_term;
    logic [7:0] pattern;
  } tsc_hits_t;

endpackage

//--- hw/tsc_top.sv
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module tsc_top #(
  parameter int MAX_LVL = 8
) (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic [tsc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [tsc_pkg::DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [tsc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [tsc_pkg::DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic SAMPLE_VALID,
  input wire tsc_pkg::tsc_hits_t SAMPLE_HITS,
  input wire logic [tsc_pkg::LVL_W-1:0] ACTIVE_LEVEL,
  output logic STORE_EN,
  output logic [tsc_pkg::LVL_W-1:0] LEVEL_COUNT,
  output logic [tsc_pkg::LVL_W-1:0] TRIGGER_LEVEL,
  output logic SEQ_REBUILT
);

  localparam int DW = tsc_pkg::DATA_W;
  localparam int LW = tsc_pkg::LVL_W;

  // Byte-lane merge of a write over the current contents
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] wd,
                                          input logic [3:0] strb);
    logic [DW-1:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic group_eval(input logic [5:0] mask, input logic [5:0] hits,
                                      input logic is_and);
    // OR of plain terms, or AND of negated terms
    return is_and ? ~|(mask & hits) : |(mask & hits);
  endfunction

  function automatic logic qual_eval(input tsc_pkg::tsc_qual_t q, input tsc_pkg::tsc_hits_t h);
    logic g1;
    logic g2;
    logic r;
    g1 = group_eval(q.g1_mask, {h.outside_bounds_term, h.inside_bounds_term, h.pattern[3:0]}, q.g1_and);
    g2 = group_eval({2'h0, q.g2_mask}, {2'h0, h.pattern[7:4]}, q.g2_and);
    unique case (q.kind)
      tsc_pkg::TSC_ANY_STATE: r = 1'b1;
      tsc_pkg::TSC_NO_STATE: r = 1'b0;
      tsc_pkg::TSC_EXPR: begin
        if (q.g2_mask == 4'h0) begin
          r = g1;
        end else if (q.g1_mask == 6'h00) begin
          r = g2;
        end else begin
          r = q.combine_and ? (g1 & g2) : (g1 | g2);
        end
      end
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic level_ok(input logic [LW-1:0] idx, input logic [LW-1:0] count);
    return (idx >= tsc_pkg::MIN_TRIG) && (idx <= count);
  endfunction

  // Qualifier store, one per level
  tsc_pkg::tsc_qual_t quals [MAX_LVL];
  tsc_pkg::tsc_qual_t next_quals [MAX_LVL];

  logic arm_ext, next_arm_ext;
  logic [LW-1:0] levels, next_levels;
  logic [LW-1:0] trig, next_trig;
  logic [LW-1:0] sel, next_sel;
  logic seq_err, next_seq_err;
  logic store_err, next_store_err;
  logic rebuilt, next_rebuilt;
  logic aw_full, next_aw_full;
  logic w_full, next_w_full;
  logic [tsc_pkg::ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [DW-1:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [DW-1:0] rdata, next_rdata;
  logic store_en, next_store_en;

  logic aw_fire, w_fire, ar_fire, do_write;
  logic [tsc_pkg::ADDR_W-1:0] wa;
  logic [DW-1:0] wd, seq_word;
  logic [3:0] ws;
  logic [LW-1:0] req_num, req_trig, max_num;
  tsc_pkg::tsc_qual_t new_q;
  logic [DW-1:0] seq_merged, arm_merged, sel_merged, qual_merged;

  assign S_AXI_AWREADY = !aw_full && !bvalid;
  assign S_AXI_WREADY = !w_full && !bvalid;
  assign S_AXI_ARREADY = !rvalid;
  assign aw_fire = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_fire = S_AXI_WVALID && S_AXI_WREADY;
  assign ar_fire = S_AXI_ARVALID && S_AXI_ARREADY;
  assign seq_word = {16'h0000, 4'h0, trig, 4'h0, levels};

  always_comb begin
    next_arm_ext = arm_ext;
    next_levels = levels;
    next_trig = trig;
    next_sel = sel;
    next_seq_err = seq_err;
    next_store_err = store_err;
    next_rebuilt = 1'b0;
    next_quals = quals;
    next_aw_full = aw_full | aw_fire;
    next_w_full = w_full | w_fire;
    next_aw_addr = aw_fire ? S_AXI_AWADDR : aw_addr;
    next_w_data = w_fire ? S_AXI_WDATA : w_data;
    next_w_strb = w_fire ? S_AXI_WSTRB : w_strb;
    next_bvalid = bvalid && !S_AXI_BREADY;
    next_bresp = bresp;
    next_rvalid = rvalid && !S_AXI_RREADY;
    next_rresp = rresp;
    next_rdata = rdata;
    wa = aw_fire ? S_AXI_AWADDR : aw_addr;
    wd = w_fire ? S_AXI_WDATA : w_data;
    ws = w_fire ? S_AXI_WSTRB : w_strb;
    do_write = (aw_full || aw_fire) && (w_full || w_fire);
    max_num = arm_ext ? tsc_pkg::MAX_LEVELS_EXT : tsc_pkg::MAX_LEVELS_RUN;
    // Merged candidate words; a function result cannot be part-selected directly
    seq_merged = merge(seq_word, wd, ws);
    arm_merged = merge({31'h0, arm_ext}, wd, ws);
    sel_merged = merge({28'h0, sel}, wd, ws);
    qual_merged = merge({{(DW-tsc_pkg::QUAL_W){1'b0}}, quals[sel[2:0] - 3'h1]}, wd, ws);
    req_num = seq_merged[tsc_pkg::SEQ_NUM_LSB +: LW];
    req_trig = seq_merged[tsc_pkg::SEQ_TRIG_LSB +: LW];
    new_q = tsc_pkg::tsc_qual_t'(qual_merged[tsc_pkg::QUAL_W-1:0]);
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = tsc_pkg::RESP_OKAY;
      unique case (wa)
        tsc_pkg::ARM_ADDR: next_arm_ext = arm_merged[0];
        tsc_pkg::SEQ_ADDR: begin
          if (req_num >= tsc_pkg::MIN_LEVELS && req_num <= max_num
              && req_trig >= tsc_pkg::MIN_TRIG && req_trig < req_num) begin
            for (int i = 0; i < MAX_LVL; i++) begin
              next_quals[i] = tsc_pkg::QUAL_DEFAULT;
            end
            next_levels = req_num;
            next_trig = req_trig;
            next_seq_err = 1'b0;
            next_rebuilt = 1'b1;
          end else begin
            next_seq_err = 1'b1;
          end
        end
        tsc_pkg::SEL_ADDR: next_sel = sel_merged[LW-1:0];
        tsc_pkg::STORE_ADDR: begin
          // Encoding has no parentheses, so any redundant grouping folds to the same word
          if (level_ok(sel, levels) && new_q.kind != tsc_pkg::TSC_BAD_KIND
              && !(new_q.kind == tsc_pkg::TSC_EXPR && new_q.g1_mask == 6'h00
                   && new_q.g2_mask == 4'h0)) begin
            next_quals[sel[2:0] - 3'h1] = new_q;
            next_store_err = 1'b0;
          end else begin
            next_store_err = 1'b1;
          end
        end
        tsc_pkg::REPLY_ADDR, tsc_pkg::STATUS_ADDR: next_bresp = tsc_pkg::RESP_OKAY;
        default: next_bresp = tsc_pkg::RESP_SLVERR;
      endcase
    end
    if (ar_fire) begin
      next_rvalid = 1'b1;
      next_rresp = tsc_pkg::RESP_OKAY;
      unique case (S_AXI_ARADDR)
        tsc_pkg::ARM_ADDR: next_rdata = {31'h0, arm_ext};
        tsc_pkg::SEQ_ADDR: next_rdata = seq_word;
        tsc_pkg::REPLY_ADDR: next_rdata = {tsc_pkg::ASCII_NL, tsc_pkg::ASCII_ZERO + {4'h0, trig},
                                           tsc_pkg::ASCII_COMMA,
                                           tsc_pkg::ASCII_ZERO + {4'h0, levels}};
        tsc_pkg::STATUS_ADDR: next_rdata = {30'h0, store_err, seq_err};
        tsc_pkg::SEL_ADDR: next_rdata = {28'h0, sel};
        tsc_pkg::STORE_ADDR: next_rdata = level_ok(sel, levels)
            ? {{(DW-tsc_pkg::QUAL_W){1'b0}}, quals[sel[2:0] - 3'h1]} : '0;
        default: begin
          next_rdata = '0;
          next_rresp = tsc_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_store_en = SAMPLE_VALID && level_ok(ACTIVE_LEVEL, levels)
                    && qual_eval(quals[ACTIVE_LEVEL[2:0] - 3'h1], SAMPLE_HITS);
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < MAX_LVL; i++) begin
        quals[i] <= tsc_pkg::QUAL_DEFAULT;
      end
      arm_ext <= 1'b0;
      levels <= tsc_pkg::RESET_LEVELS;
      trig <= tsc_pkg::RESET_TRIG;
      sel <= tsc_pkg::MIN_TRIG;
      seq_err <= 1'b0;
      store_err <= 1'b0;
      rebuilt <= 1'b0;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= tsc_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= tsc_pkg::RESP_OKAY;
      rdata <= '0;
      store_en <= 1'b0;
    end else begin
      quals <= next_quals;
      arm_ext <= next_arm_ext;
      levels <= next_levels;
      trig <= next_trig;
      sel <= next_sel;
      seq_err <= next_seq_err;
      store_err <= next_store_err;
      rebuilt <= next_rebuilt;
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      store_en <= next_store_en;
    end
  end

  assign S_AXI_BVALID = bvalid;
  assign S_AXI_BRESP = bresp;
  assign S_AXI_RVALID = rvalid;
  assign S_AXI_RRESP = rresp;
  assign S_AXI_RDATA = rdata;
  assign STORE_EN = store_en;
  assign LEVEL_COUNT = levels;
  assign TRIGGER_LEVEL = trig;
  assign SEQ_REBUILT = rebuilt;

endmodule
`default_nettype wire

//--- tb/tsc_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module tsc_ctl (
  input wire logic SYS_CLK,
  output logic [5:0] S_AXI_AWADDR,
  output logic [5:0] S_AXI_ARADDR,
  output logic [31:0] S_AXI_WDATA,
  output logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_AWVALID,
  output logic S_AXI_WVALID,
  output logic S_AXI_ARVALID,
  output logic S_AXI_BREADY,
  output logic S_AXI_RREADY,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic [31:0] S_AXI_RDATA
);
  assign S_AXI_WSTRB = 4'hF;
  assign S_AXI_BREADY = 1'b1;
  assign S_AXI_RREADY = 1'b1;
  initial begin
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID} = 3'h0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 44'h0;
  end
  // Each channel holds until its own ready is seen at a rising edge
  task automatic acc(input logic we, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic [1:0] r);
    logic aw_on, w_on, ar_on, done;
    aw_on = we;
    w_on = we;
    ar_on = !we;
    done = 1'b0;
    S_AXI_AWADDR <= a;
    S_AXI_ARADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= we;
    S_AXI_WVALID <= we;
    S_AXI_ARVALID <= !we;
    while (!done) begin
      @(posedge SYS_CLK);
      if (aw_on && S_AXI_AWREADY) begin
        aw_on = 1'b0;
        S_AXI_AWVALID <= 1'b0;
      end
      if (w_on && S_AXI_WREADY) begin
        w_on = 1'b0;
        S_AXI_WVALID <= 1'b0;
      end
      if (ar_on && S_AXI_ARREADY) begin
        ar_on = 1'b0;
        S_AXI_ARVALID <= 1'b0;
      end
      if (we ? S_AXI_BVALID : S_AXI_RVALID) begin
        done = 1'b1;
        r = we ? S_AXI_BRESP : S_AXI_RRESP;
        q = S_AXI_RDATA;
      end
    end
  endtask
endmodule
`default_nettype wire

//--- tb/tsc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module tsc_chk #(
  parameter int MAX_LVL = 8
) (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic SAMPLE_VALID,
  input wire logic STORE_EN,
  input wire logic SEQ_REBUILT,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic [3:0] ACTIVE_LEVEL,
  input wire logic [3:0] LEVEL_COUNT,
  input wire logic [3:0] TRIGGER_LEVEL
);
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);
  sequence wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence lvl_missing;
    SAMPLE_VALID && (ACTIVE_LEVEL == 4'h0 || ACTIVE_LEVEL > LEVEL_COUNT);
  endsequence
  lvl_range_a: assert property (LEVEL_COUNT >= tsc_pkg::MIN_LEVELS && LEVEL_COUNT <= MAX_LVL)
    else $error("level count out of range");
  trig_range_a: assert property (TRIGGER_LEVEL >= tsc_pkg::MIN_TRIG && TRIGGER_LEVEL < LEVEL_COUNT)
    else $error("trigger level out of range");
  seq_guard_a: assert property ($changed(LEVEL_COUNT) || $changed(TRIGGER_LEVEL) |-> $rose(S_AXI_BVALID))
    else $error("settings moved without a write");
  rebuild_src_a: assert property (SEQ_REBUILT |-> S_AXI_BVALID || $past(S_AXI_BVALID))
    else $error("rebuild without a write");
  rebuild_pulse_a: assert property (SEQ_REBUILT |=> !SEQ_REBUILT)
    else $error("rebuild pulse too long");
  store_idle_a: assert property (!SAMPLE_VALID |=> !STORE_EN)
    else $error("store without a sample");
  store_level_a: assert property (lvl_missing |=> !STORE_EN)
    else $error("store at a missing level");
  write_answer_a: assert property (wr_taken |=> S_AXI_BVALID)
    else $error("write not answered");
endmodule
bind tsc_top tsc_chk #(
  .MAX_LVL(MAX_LVL)
) tsc_chk_i (
  .SYS_CLK(SYS_CLK),
  .RSTN(RSTN),
  .SAMPLE_VALID(SAMPLE_VALID),
  .STORE_EN(STORE_EN),
  .SEQ_REBUILT(SEQ_REBUILT),
  .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID),
  .ACTIVE_LEVEL(ACTIVE_LEVEL),
  .LEVEL_COUNT(LEVEL_COUNT),
  .TRIGGER_LEVEL(TRIGGER_LEVEL)
);
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic SYS_CLK, RSTN, SAMPLE_VALID, STORE_EN, SEQ_REBUILT, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID;
  logic S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [5:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, q;
  logic [3:0] S_AXI_WSTRB, ACTIVE_LEVEL, LEVEL_COUNT, TRIGGER_LEVEL;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, resp;
  tsc_pkg::tsc_hits_t SAMPLE_HITS;
  int error_cnt = 0, cmp_count = 0, cyc = 0, rebuild_cnt = 0;
  tsc_top tsc_top_i (.*);
  tsc_ctl tsc_ctl_i (.*);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input string n, input logic [5:0] a, input logic [31:0] e);
    tsc_ctl_i.acc(1'b0, a, 32'h0, q, resp);
    chk(n, e, q);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    tsc_ctl_i.acc(1'b1, a, d, q, resp);
  endtask
  task automatic smp(input logic [3:0] l, input logic [9:0] h, input logic e);
    SAMPLE_VALID <= 1'b1;
    ACTIVE_LEVEL <= l;
    SAMPLE_HITS <= h;
    @(posedge SYS_CLK);
    SAMPLE_VALID <= 1'b0;
    @(negedge SYS_CLK);
    chk("store_en", {31'h0, e}, {31'h0, STORE_EN});
    @(posedge SYS_CLK);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc > 2000) begin
      error_cnt++;
      results;
    end
  end
  always @(posedge SYS_CLK) begin
    if (SEQ_REBUILT) begin
      rebuild_cnt++;
    end
  end
  initial begin
    SYS_CLK = 1'b0;
    forever #4 SYS_CLK = ~SYS_CLK;
  end
  task automatic t_seq;
    wr(tsc_pkg::SEQ_ADDR, 32'h0000_0304);
    rd("reply", tsc_pkg::REPLY_ADDR, 32'h0A33_2C34);
    wr(tsc_pkg::SEQ_ADDR, 32'h0000_0708);
    wr(tsc_pkg::SEQ_ADDR, 32'h0000_0808);
    rd("seq", tsc_pkg::SEQ_ADDR, 32'h0000_0708);
    rd("status", tsc_pkg::STATUS_ADDR, 32'h0000_0001);
    wr(tsc_pkg::ARM_ADDR, 32'h0000_0001);
    wr(tsc_pkg::SEQ_ADDR, 32'h0000_0608);
    rd("seq", tsc_pkg::SEQ_ADDR, 32'h0000_0708);
    wr(tsc_pkg::SEQ_ADDR, 32'h0000_0607);
    rd("reply", tsc_pkg::REPLY_ADDR, 32'h0A36_2C37);
    $display("sequence test done");
  endtask
  task automatic t_store;
    wr(tsc_pkg::SEL_ADDR, 32'h0000_0002);
    smp(4'h2, 10'h001, 1'b1);
    wr(tsc_pkg::STORE_ADDR, 32'h0000_0206);
    smp(4'h2, 10'h010, 1'b1);
    smp(4'h2, 10'h002, 1'b0);
    smp(4'h8, 10'h001, 1'b0);
    wr(tsc_pkg::SEQ_ADDR, 32'h0000_0607);
    rd("store", tsc_pkg::STORE_ADDR, 32'h0);
    wr(tsc_pkg::SEL_ADDR, 32'h0000_0008);
    wr(tsc_pkg::STORE_ADDR, 32'h0000_0206);
    rd("status", tsc_pkg::STATUS_ADDR, 32'h0000_0002);
    wr(6'h18, 32'h0);
    chk("bresp", {30'h0, tsc_pkg::RESP_SLVERR}, {30'h0, resp});
    $display("store test done");
  endtask
  task automatic t_qual;
    wr(tsc_pkg::SEL_ADDR, 32'h0000_0003);
    wr(tsc_pkg::STORE_ADDR, 32'h0000_0001);
    smp(4'h3, 10'h3FF, 1'b0);
    wr(tsc_pkg::STORE_ADDR, 32'h0000_430E);
    smp(4'h3, 10'h010, 1'b1);
    smp(4'h3, 10'h011, 1'b0);
    smp(4'h3, 10'h000, 1'b0);
    wr(tsc_pkg::STORE_ADDR, 32'h0000_0042);
    smp(4'h3, 10'h100, 1'b1);
    smp(4'h3, 10'h200, 1'b0);
    wr(tsc_pkg::STORE_ADDR, 32'h0000_0003);
    wr(tsc_pkg::STORE_ADDR, 32'h0000_0002);
    rd("store_keep", tsc_pkg::STORE_ADDR, 32'h0000_0042);
    rd("status", tsc_pkg::STATUS_ADDR, 32'h0000_0002);
    smp(4'h2, 10'h000, 1'b1);
    $display("qualifier test done");
  endtask
  task automatic t_limits;
    int n;
    wr(tsc_pkg::ARM_ADDR, 32'h0000_0000);
    rd("arm", tsc_pkg::ARM_ADDR, 32'h0000_0000);
    n = rebuild_cnt;
    wr(tsc_pkg::SEQ_ADDR, 32'h0000_0109);
    wr(tsc_pkg::SEQ_ADDR, 32'h0000_0001);
    wr(tsc_pkg::SEQ_ADDR, 32'h0000_0202);
    chk("levels_kept", 32'h0000_0007, {28'h0, LEVEL_COUNT});
    chk("trig_kept", 32'h0000_0006, {28'h0, TRIGGER_LEVEL});
    wr(tsc_pkg::SEQ_ADDR, 32'h0000_0102);
    chk("level_count", 32'h0000_0002, {28'h0, LEVEL_COUNT});
    chk("trigger_level", 32'h0000_0001, {28'h0, TRIGGER_LEVEL});
    @(posedge SYS_CLK);
    chk("rebuilds", n + 1, rebuild_cnt);
    rd("status", tsc_pkg::STATUS_ADDR, 32'h0000_0002);
    $display("limits test done");
  endtask
  task automatic t_reset;
    wr(tsc_pkg::SEQ_ADDR, 32'h0000_0405);
    wr(tsc_pkg::ARM_ADDR, 32'h0000_0001);
    wr(tsc_pkg::SEL_ADDR, 32'h0000_0005);
    RSTN <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    chk("rst_levels", 32'h0000_0002, {28'h0, LEVEL_COUNT});
    chk("rst_trig", 32'h0000_0001, {28'h0, TRIGGER_LEVEL});
    RSTN <= 1'b1;
    rd("rst_sel", tsc_pkg::SEL_ADDR, 32'h0000_0001);
    rd("rst_arm", tsc_pkg::ARM_ADDR, 32'h0000_0000);
    rd("rst_store", tsc_pkg::STORE_ADDR, 32'h0000_0000);
    smp(4'h1, 10'h000, 1'b1);
    $display("reset test done");
  endtask
  initial begin
    {RSTN, SAMPLE_VALID, ACTIVE_LEVEL, SAMPLE_HITS} = '0;
    repeat (6) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    t_seq;
    t_store;
    t_qual;
    t_limits;
    t_reset;
    results;
  end
endmodule
`default_nettype wire
